/* File: rtl/pps_pkg.sv */
package pps_pkg;
  // register addresses
  localparam logic [7:0] ADDR_STATUS2 = 8'h0f;
  localparam logic [7:0] ADDR_CFG1    = 8'h11;

  // status register field positions
  localparam int unsigned ST_RATION_BIT = 7;
  localparam int unsigned ST_CC_BIT     = 4;
  localparam int unsigned ST_PEN_BIT    = 3;

  // configuration register field positions
  localparam int unsigned CFG_MASK_BIT  = 7;
  localparam int unsigned CFG_DSCHG_BIT = 5;
  localparam int unsigned CFG_OVR_BIT   = 4;
  localparam int unsigned CFG_TIME_LSB  = 2;

  // reset values and fixed read values
  localparam logic [1:0] CFG_TIME_RESET = 2'h1;
  localparam logic [7:0] CFG_FIXED_ONES = 8'h02;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // discharge timing: duration is (sel + 1) steps of 100 ms
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned DSCHG_STEP_MS = 100;
  localparam int unsigned DSCHG_STEP_CYC = DSCHG_STEP_MS * (CLK_HZ / 1000);
endpackage

/* File: rtl/pps_dschg_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module pps_dschg_timer #(
  parameter int unsigned STEP_CYCLES = pps_pkg::DSCHG_STEP_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [1:0] sel,
  output logic            busy
);

  typedef struct packed {
    logic        busy;
    logic [1:0]  steps;
    logic [23:0] cnt;
  } pps_tmr_t;

  pps_tmr_t st;
  pps_tmr_t next_st;

  // counts (sel + 1) steps, each of STEP_CYCLES clocks
  always_comb
  begin
    next_st = st;
    if (start && !st.busy)
    begin
      next_st.busy  = 1'b1;
      next_st.steps = sel;
      next_st.cnt   = 24'(STEP_CYCLES - 1);
    end
    else if (st.busy)
    begin
      if (st.cnt != 24'h000000)
        next_st.cnt = st.cnt - 24'h000001;
      else if (st.steps != 2'h0)
      begin
        next_st.steps = st.steps - 2'h1;
        next_st.cnt   = 24'(STEP_CYCLES - 1);
      end
      else
        next_st.busy = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign busy = st.busy;

  chk_tmr_start: assert property (@(posedge mclk) disable iff (!rstn) // [R11]
    (start && !st.busy) |=> busy) else $error("discharge did not start");

endmodule
`default_nettype wire

/* File: rtl/pps_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R01] set ration-done bit 7 on delivered charge
// [R02] status read clears ration-done flag
// [R03] ration reset or disable clears flag
// [R04] bit 4 shows constant-current mode
// [R05] bit 3 equals pin OR override
// [R06] status at 0x0f, other bits zero
// [R07] configuration held across sleep
// [R08] config at 0x11, time resets 01
// [R09] mask set: alert only overcurrent, thermal
// [R10] mask clear: alert on any event
// [R11] time field selects 100 to 400 ms; a discharge started by a write uses the field held before it
// [R12] forced discharge opens switch, host clears
// [R13] port 1 enable is pin OR override
// [R14] set wins over clearing read
// [R15] unimplemented bits fixed, writes ignored
module pps_regs #(
  parameter int unsigned DSCHG_STEP_CYCLES = pps_pkg::DSCHG_STEP_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       port2_ration_hit,
  input  wire logic       port2_ration_reset,
  input  wire logic       port2_ration_enable,
  input  wire logic       port2_const_current_active,
  input  wire logic       port2_power_enable_pin,
  input  wire logic       port2_power_enable_override,
  input  wire logic       port1_power_enable_pin,
  input  wire logic       port1_overcurrent_event,
  input  wire logic       thermal_shutdown_event,
  input  wire logic       port1_other_event,
  input  wire logic       active_state,
  input  wire logic       bus_discharge_allow,
  output logic            port1_alert,
  output logic            port1_switch_en,
  output logic            port1_discharging,
  output logic      [1:0] discharge_duration_sel
);

  typedef struct packed {
    logic       pen2_meta;
    logic       pen2_sync;
    logic       pen1_meta;
    logic       pen1_sync;
    logic       cc_meta;
    logic       cc_sync;
    logic       port2_ration_done;
    logic       port2_const_current;
    logic       port2_effective_power_enable;
    logic       port1_alert_filter;
    logic       port1_force_discharge;
    logic       port1_power_enable_override;
    logic [1:0] time_sel;
    logic [7:0] rdata;
    logic       alert;
    logic       switch_en;
    logic       dschg;
  } pps_state_t;

  pps_state_t st;
  pps_state_t next_st;
  logic       tmr_busy;
  logic       tmr_start;

  // assembles the status byte; unused bits read zero
  function automatic logic [7:0] pps_status_byte(input pps_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[pps_pkg::ST_RATION_BIT] = s.port2_ration_done;
    v[pps_pkg::ST_CC_BIT]     = s.port2_const_current;
    v[pps_pkg::ST_PEN_BIT]    = s.port2_effective_power_enable;
    return v;
  endfunction

  // assembles the configuration byte with its fixed bits
  function automatic logic [7:0] pps_cfg_byte(input pps_state_t s);
    logic [7:0] v;
    v = pps_pkg::CFG_FIXED_ONES;
    v[pps_pkg::CFG_MASK_BIT]  = s.port1_alert_filter;
    v[pps_pkg::CFG_DSCHG_BIT] = s.port1_force_discharge;
    v[pps_pkg::CFG_OVR_BIT]   = s.port1_power_enable_override;
    v[pps_pkg::CFG_TIME_LSB +: 2] = s.time_sel;
    return v;
  endfunction

  wire rd_status = reg_rd && (reg_addr == pps_pkg::ADDR_STATUS2);
  wire wr_cfg    = reg_wr && (reg_addr == pps_pkg::ADDR_CFG1);

  // a write of 1 to the force bit starts the discharge timer when active_state and bus_discharge_allow are both set
  assign tmr_start = wr_cfg && reg_wdata[pps_pkg::CFG_DSCHG_BIT]
                     && active_state && bus_discharge_allow; // [R12]

  pps_dschg_timer #(
    .STEP_CYCLES (DSCHG_STEP_CYCLES)
  ) u_timer (
    .mclk  (mclk),
    .rstn  (rstn),
    .start (tmr_start),
    .sel   (st.time_sel),
    .busy  (tmr_busy)
  );

  // next state of the whole block
  always_comb
  begin
    next_st = st;
    // pin synchronisers
    next_st.pen2_meta = port2_power_enable_pin;
    next_st.pen2_sync = st.pen2_meta;
    next_st.pen1_meta = port1_power_enable_pin;
    next_st.pen1_sync = st.pen1_meta;
    next_st.cc_meta   = port2_const_current_active;
    next_st.cc_sync   = st.cc_meta;

    // status bits
    next_st.port2_const_current = st.cc_sync; // [R04]
    next_st.port2_effective_power_enable =
      st.pen2_sync | port2_power_enable_override; // [R05]

    // ration-done: set wins over every clear
    if (port2_ration_hit)
      next_st.port2_ration_done = 1'b1; // [R01] [R14]
    else if (rd_status)
      next_st.port2_ration_done = 1'b0; // [R02]
    else if (port2_ration_reset || !port2_ration_enable)
      next_st.port2_ration_done = 1'b0; // [R03]

    // configuration writes; nothing else touches these bits
    if (wr_cfg)
    begin
      next_st.port1_alert_filter          = reg_wdata[pps_pkg::CFG_MASK_BIT]; // [R08]
      next_st.port1_force_discharge       = reg_wdata[pps_pkg::CFG_DSCHG_BIT];
      next_st.port1_power_enable_override = reg_wdata[pps_pkg::CFG_OVR_BIT];
      next_st.time_sel = reg_wdata[pps_pkg::CFG_TIME_LSB +: 2]; // [R11]
    end

    // read data, registered
    if (reg_rd)
    begin
      case (reg_addr)
        pps_pkg::ADDR_STATUS2: next_st.rdata = pps_status_byte(st); // [R06]
        pps_pkg::ADDR_CFG1:    next_st.rdata = pps_cfg_byte(st); // [R15]
        default:               next_st.rdata = pps_pkg::UNMAPPED_READ;
      endcase
    end

    // alert: filter keeps only overcurrent and thermal
    if (st.port1_alert_filter)
      next_st.alert = port1_overcurrent_event | thermal_shutdown_event; // [R09]
    else
      next_st.alert = port1_overcurrent_event | thermal_shutdown_event
                      | port1_other_event; // [R10]

    // switch: pin OR override, held open while forced discharge is set
    next_st.switch_en = (st.pen1_sync | st.port1_power_enable_override)
                        & ~st.port1_force_discharge; // [R13] [R12]
    next_st.dschg     = tmr_busy;
  end

  // state register; configuration has no sleep-related clear
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st          <= '0;
      st.time_sel <= pps_pkg::CFG_TIME_RESET; // [R08]
    end
    else
      st <= next_st; // [R07]
  end

  assign reg_rdata              = st.rdata;
  assign port1_alert            = st.alert;
  assign port1_switch_en        = st.switch_en;
  assign port1_discharging      = st.dschg;
  assign discharge_duration_sel = st.time_sel;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  chk_ration_set: assert property ( // [R01]
    port2_ration_hit |=> st.port2_ration_done) else $error("ration flag not set");

  chk_ration_hold: assert property ( // [R01]
    (st.port2_ration_done && !rd_status && !port2_ration_reset && port2_ration_enable)
    |=> st.port2_ration_done) else $error("ration flag dropped");

  chk_ration_no_set: assert property ( // [R01]
    (!st.port2_ration_done && !port2_ration_hit) |=> !st.port2_ration_done)
    else $error("ration flag set without event");

  chk_read_clears: assert property ( // [R02]
    (rd_status && !port2_ration_hit) |=> !st.port2_ration_done)
    else $error("read did not clear flag");

  chk_auto_clear: assert property ( // [R03]
    ((port2_ration_reset || !port2_ration_enable) && !port2_ration_hit)
    |=> !st.port2_ration_done) else $error("auto clear failed");

  chk_read_sees_set: assert property ( // [R14]
    (rd_status && st.port2_ration_done) |=> reg_rdata[7] && st.port2_ration_done == 1'b0
    || $past(port2_ration_hit)) else $error("status read lost flag");

  chk_clear_race: assert property ( // [R14]
    (rd_status && port2_ration_hit) |=> st.port2_ration_done)
    else $error("event lost against clearing read");

  chk_reset_race: assert property ( // [R14]
    ((port2_ration_reset || !port2_ration_enable) && port2_ration_hit)
    |=> st.port2_ration_done) else $error("event lost against auto clear");

  chk_status_layout: assert property ( // [R06]
    rd_status |=> (reg_rdata[6:5] == 2'h0) && (reg_rdata[2:0] == 3'h0)
    && (reg_rdata[3] == $past(st.port2_effective_power_enable))
    && (reg_rdata[4] == $past(st.port2_const_current)))
    else $error("status byte wrong");

  chk_rdata_hold: assert property ( // [R06]
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  chk_cc_follow: assert property ( // [R04]
    $rose(port2_const_current_active) |-> ##3 st.port2_const_current)
    else $error("cc mode not reported");

  chk_cc_clear: assert property ( // [R04]
    !port2_const_current_active [*3] |=> !st.port2_const_current)
    else $error("cc mode reported while off");

  chk_pen2_or: assert property ( // [R05]
    port2_power_enable_override |=> st.port2_effective_power_enable)
    else $error("effective enable wrong");

  chk_pen2_pin: assert property ( // [R05]
    port2_power_enable_pin [*3] |=> st.port2_effective_power_enable)
    else $error("pin did not set effective enable");

  chk_pen2_off: assert property ( // [R05]
    (!port2_power_enable_pin && !port2_power_enable_override) [*3]
    |=> !st.port2_effective_power_enable) else $error("effective enable stuck");

  chk_cfg_write: assert property ( // [R08]
    wr_cfg |=> (st.time_sel == $past(reg_wdata[3:2]))
    && (st.port1_alert_filter == $past(reg_wdata[7])))
    else $error("config write lost");

  chk_cfg_read: assert property ( // [R15]
    (reg_rd && reg_addr == pps_pkg::ADDR_CFG1) |=> reg_rdata[1:0] == 2'h2
    && reg_rdata[6] == 1'b0) else $error("fixed config bits wrong");

  chk_unmapped_read: assert property ( // [R15]
    (reg_rd && reg_addr != pps_pkg::ADDR_STATUS2 && reg_addr != pps_pkg::ADDR_CFG1)
    |=> reg_rdata == pps_pkg::UNMAPPED_READ) else $error("unmapped read not fixed");

  chk_other_write: assert property ( // [R15]
    (reg_wr && reg_addr != pps_pkg::ADDR_CFG1) |=> $stable(st.port1_alert_filter)
    && $stable(st.port1_power_enable_override)) else $error("stray write took effect");

  chk_alert_mask: assert property ( // [R09]
    (st.port1_alert_filter && !port1_overcurrent_event && !thermal_shutdown_event)
    |=> !port1_alert) else $error("masked alert leaked");

  chk_alert_kept: assert property ( // [R09]
    (port1_overcurrent_event || thermal_shutdown_event) |=> port1_alert)
    else $error("overcurrent or thermal gave no alert");

  chk_alert_any: assert property ( // [R10]
    (!st.port1_alert_filter && port1_other_event) |=> port1_alert)
    else $error("unmasked event gave no alert");

  chk_alert_quiet: assert property ( // [R10]
    !(port1_overcurrent_event || thermal_shutdown_event || port1_other_event)
    |=> !port1_alert) else $error("alert without event");

  chk_switch_open: assert property ( // [R12]
    st.port1_force_discharge |=> !port1_switch_en)
    else $error("switch closed during discharge");

  chk_dschg_gate: assert property ( // [R12]
    (wr_cfg && !(active_state && bus_discharge_allow) && !tmr_busy) |=> !tmr_busy)
    else $error("discharge started outside active");

  chk_pen1_or: assert property ( // [R13]
    (st.port1_power_enable_override && !st.port1_force_discharge) |=> port1_switch_en)
    else $error("override did not enable");

  chk_pen1_pin: assert property ( // [R13]
    (port1_power_enable_pin && !st.port1_force_discharge) [*3] |=> port1_switch_en)
    else $error("pin did not enable switch");

  chk_cfg_hold: assert property ( // [R07]
    !wr_cfg |=> $stable(st.time_sel) && $stable(st.port1_force_discharge))
    else $error("config changed without write");

  chk_dschg_run: assert property ( // [R11]
    tmr_start && !tmr_busy |-> ##2 port1_discharging)
    else $error("discharge output missing");

endmodule
`default_nettype wire

/* File: dv/pps_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pps_host_model (
  input  wire logic       mclk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // bus idle at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle write strobe; released lines show the inverse, not the old value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // one-cycle read strobe, data taken the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge mclk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] addr, wdata, rdata, rd;
  logic       wr, rds, alert, sw_en, dis;
  logic       hit = 1'b0, rrst = 1'b0, ren = 1'b1, cc = 1'b0, pin2 = 1'b0;
  logic       ovr2 = 1'b0, pin1 = 1'b0, ov = 1'b0, therm = 1'b0, oth = 1'b0;
  logic       act = 1'b0, allow = 1'b0;
  logic [1:0] dsel;
  int         n_fail = 0;
  int         num_checks = 0;
  // clock, 25 ns period
  always #12.5 mclk = ~mclk;
  pps_host_model host (.mclk(mclk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rds), .reg_rdata(rdata));
  pps_regs #(.DSCHG_STEP_CYCLES(20)) dut (.mclk(mclk), .rstn(rstn), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rds), .reg_rdata(rdata),
    .port2_ration_hit(hit), .port2_ration_reset(rrst), .port2_ration_enable(ren),
    .port2_const_current_active(cc), .port2_power_enable_pin(pin2),
    .port2_power_enable_override(ovr2), .port1_power_enable_pin(pin1),
    .port1_overcurrent_event(ov), .thermal_shutdown_event(therm), .port1_other_event(oth),
    .active_state(act), .bus_discharge_allow(allow), .port1_alert(alert),
    .port1_switch_en(sw_en), .port1_discharging(dis), .discharge_duration_sel(dsel));
  // compare one value
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read a register and compare
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rd);
    chk(rd, exp);
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog, well beyond the few hundred cycles the tests take
  initial
  begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    print_verdict();
  end
  // test sequence
  initial
  begin
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    rdchk(pps_pkg::ADDR_CFG1, 8'h06);
    rdchk(pps_pkg::ADDR_STATUS2, 8'h00);
    rdchk(8'h20, 8'h00);
    chk({6'h00, dsel}, 8'h01);
    $display("test reset done");
    // flag set, event during clearing read, clear on read
    hit = 1'b1;
    rdchk(pps_pkg::ADDR_STATUS2, 8'h80);
    hit = 1'b0;
    rdchk(pps_pkg::ADDR_STATUS2, 8'h80);
    rdchk(pps_pkg::ADDR_STATUS2, 8'h00);
    // event and rationing reset in one cycle: the event must win
    hit = 1'b1;
    rrst = 1'b1;
    @(negedge mclk);
    hit = 1'b0;
    rrst = 1'b0;
    rdchk(pps_pkg::ADDR_STATUS2, 8'h80);
    // automatic clears by rationing reset and by disable
    hit = 1'b1;
    @(negedge mclk);
    hit = 1'b0;
    rrst = 1'b1;
    @(negedge mclk);
    rrst = 1'b0;
    rdchk(pps_pkg::ADDR_STATUS2, 8'h00);
    hit = 1'b1;
    @(negedge mclk);
    hit = 1'b0;
    ren = 1'b0;
    @(negedge mclk);
    ren = 1'b1;
    rdchk(pps_pkg::ADDR_STATUS2, 8'h00);
    $display("test ration flag done");
    // constant-current and effective enable bits
    cc = 1'b1;
    pin2 = 1'b1;
    repeat (4) @(negedge mclk);
    rdchk(pps_pkg::ADDR_STATUS2, 8'h18);
    cc = 1'b0;
    pin2 = 1'b0;
    ovr2 = 1'b1;
    repeat (4) @(negedge mclk);
    rdchk(pps_pkg::ADDR_STATUS2, 8'h08);
    ovr2 = 1'b0;
    $display("test status bits done");
    // config fields, fixed bits, sleep retention, read-only status
    host.wr(pps_pkg::ADDR_CFG1, 8'hff);
    rdchk(pps_pkg::ADDR_CFG1, 8'hbe);
    chk({7'h00, dis}, 8'h00);
    host.wr(pps_pkg::ADDR_STATUS2, 8'hff);
    rdchk(pps_pkg::ADDR_STATUS2, 8'h00);
    act = 1'b1;
    repeat (3) @(negedge mclk);
    act = 1'b0;
    rdchk(pps_pkg::ADDR_CFG1, 8'hbe);
    chk({6'h00, dsel}, 8'h03);
    host.wr(pps_pkg::ADDR_CFG1, 8'h00);
    rdchk(pps_pkg::ADDR_CFG1, 8'h02);
    $display("test config done");
    // alert filtering for each mask value and event source
    for (int i = 0; i < 6; i++)
    begin
      host.wr(pps_pkg::ADDR_CFG1, {i[0], 7'h00});
      {ov, therm, oth} = 3'b100 >> (i / 2);
      repeat (2) @(negedge mclk);
      chk({7'h00, alert}, {7'h00, !(i[0] && oth)});
      {ov, therm, oth} = 3'b000;
    end
    $display("test alert done");
    // port 1 switch enable from pin or override
    pin1 = 1'b1;
    repeat (4) @(negedge mclk);
    chk({7'h00, sw_en}, 8'h01);
    pin1 = 1'b0;
    repeat (4) @(negedge mclk);
    chk({7'h00, sw_en}, 8'h00);
    host.wr(pps_pkg::ADDR_CFG1, 8'h10);
    repeat (2) @(negedge mclk);
    chk({7'h00, sw_en}, 8'h01);
    // forced discharge, shortest duration of one 20-cycle step
    act = 1'b1;
    allow = 1'b1;
    host.wr(pps_pkg::ADDR_CFG1, 8'h30);
    repeat (3) @(negedge mclk);
    chk({6'h00, dis, sw_en}, 8'h02);
    repeat (15) @(negedge mclk);
    chk({7'h00, dis}, 8'h01);
    repeat (15) @(negedge mclk);
    chk({7'h00, dis}, 8'h00);
    rdchk(pps_pkg::ADDR_CFG1, 8'h32);
    host.wr(pps_pkg::ADDR_CFG1, 8'h10);
    repeat (3) @(negedge mclk);
    chk({7'h00, sw_en}, 8'h01);
    // two-step discharge: time field 01 written before the force bit
    host.wr(pps_pkg::ADDR_CFG1, 8'h04);
    host.wr(pps_pkg::ADDR_CFG1, 8'h24);
    repeat (38) @(negedge mclk);
    chk({7'h00, dis}, 8'h01);
    repeat (4) @(negedge mclk);
    chk({7'h00, dis}, 8'h00);
    host.wr(pps_pkg::ADDR_CFG1, 8'h04);
    $display("test discharge done");
    print_verdict();
  end
endmodule
`default_nettype wire
